//--- inc/rosb_pkg.sv
// package: register map, field layout and sizes of the remappable output select bank
package rosb_pkg;

  // --------------------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------------------
  localparam int NUM_REGS      = 7;
  localparam int NUM_PINS      = 14;
  localparam int FUNC_W        = 6;
  localparam int REG_W         = 16;
  localparam int FIRST_PIN     = 46;

  // --------------------------------------------------------------------------
  // register byte offsets (one aligned word each)
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_SEL_46_47 = 8'h00;
  localparam logic [7:0] OFS_SEL_48_49 = 8'h04;
  localparam logic [7:0] OFS_SEL_50_51 = 8'h08;
  localparam logic [7:0] OFS_SEL_52_53 = 8'h0c;
  localparam logic [7:0] OFS_SEL_54_55 = 8'h10;
  localparam logic [7:0] OFS_SEL_56_57 = 8'h14;
  localparam logic [7:0] OFS_SEL_58_59 = 8'h18;
  localparam logic [7:0] OFS_LAST      = OFS_SEL_58_59;

  // --------------------------------------------------------------------------
  // field positions and reset value
  // --------------------------------------------------------------------------
  localparam int ODD_LSB       = 8;
  localparam int EVEN_LSB      = 0;
  localparam logic [5:0] FUNC_RESET = 6'h00;
  localparam logic [5:0] FUNC_NONE  = 6'h00;

  // --------------------------------------------------------------------------
  // ahb-lite codes
  // --------------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum {ST_IDLE, ST_WRITE, ST_READ} rosb_phase_t;

endpackage

//--- inc/rosb_sel_if.sv
// interface: selector write port from bus control to bank, stored codes from bank to read path and pin muxes
`timescale 1ns/1ps
interface rosb_sel_if;
  import rosb_pkg::*;
  logic                  wr_en;
  logic [2:0]            wr_idx;
  logic [REG_W-1:0]      wr_data;
  logic [FUNC_W-1:0]     odd_func [NUM_REGS];
  logic [FUNC_W-1:0]     even_func [NUM_REGS];

  modport bank (input wr_en, input wr_idx, input wr_data, output odd_func, output even_func);
  modport ctrl (output wr_en, output wr_idx, output wr_data, input odd_func, input even_func);
endinterface

//--- hdl/rosb_sel_reg.sv
// module: one selector register holding the codes of one pin pair
`timescale 1ns/1ps
module rosb_sel_reg
  import rosb_pkg::*;
#(
  parameter logic [2:0] IDX = 3'h0
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [2:0]        wr_idx_i,
  input  wire logic [REG_W-1:0]  wr_data_i,
  output logic      [FUNC_W-1:0] odd_func_o,
  output logic      [FUNC_W-1:0] even_func_o
);

  typedef struct packed {
    logic [FUNC_W-1:0] odd_func;
    logic [FUNC_W-1:0] even_func;
  } rosb_sel_state_t;

  rosb_sel_state_t state_reg;
  rosb_sel_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_en_i && wr_idx_i == IDX) begin
      // bits 15:14 and 7:6 have no storage, so they drop here
      state_next.odd_func  = wr_data_i[ODD_LSB +: FUNC_W];
      state_next.even_func = wr_data_i[EVEN_LSB +: FUNC_W];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '{odd_func: FUNC_RESET, even_func: FUNC_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign odd_func_o  = state_reg.odd_func;
  assign even_func_o = state_reg.even_func;

endmodule

//--- hdl/rosb_pin_mux.sv
// module: output multiplexer of one remappable pin
`timescale 1ns/1ps
module rosb_pin_mux
  import rosb_pkg::*;
#(
  parameter int NUM_FUNCS = 64
) (
  input  wire logic [FUNC_W-1:0]    func_i,
  input  wire logic [NUM_FUNCS-1:0] periph_out_i,
  output logic                      pin_o
);

  if (NUM_FUNCS < 1 || NUM_FUNCS > (1 << FUNC_W)) begin : g_bad_num_funcs
    $error("rosb_pin_mux: NUM_FUNCS out of range");
  end

  // code zero and codes past the last peripheral leave the pin at zero
  always_comb begin
    if (func_i == FUNC_NONE || int'(func_i) >= NUM_FUNCS) begin
      pin_o = 1'b0;
    end else begin
      pin_o = periph_out_i[func_i];
    end
  end

endmodule

//--- hdl/rosb_top.sv
// module: remappable output select bank for pins 46..59 with ahb-lite access
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module rosb_top
  import rosb_pkg::*;
#(
  parameter int NUM_FUNCS = 64
) (
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RESET_N_I,
  input  wire logic                    HSEL_I,
  input  wire logic [31:0]             HADDR_I,
  input  wire logic [1:0]              HTRANS_I,
  input  wire logic                    HWRITE_I,
  input  wire logic [2:0]              HSIZE_I,
  input  wire logic [31:0]             HWDATA_I,
  input  wire logic                    HREADY_I,
  output logic      [31:0]             HRDATA_O,
  output logic                         HREADYOUT_O,
  output logic                         HRESP_O,
  input  wire logic [NUM_FUNCS-1:0]    PERIPH_OUT_I,
  output logic      [NUM_PINS-1:0]     REMAP_PIN_O,
  output logic      [NUM_PINS*FUNC_W-1:0] PIN_OUT_FUNC_O
);

  // --------------------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------------------
  if (NUM_FUNCS < 1 || NUM_FUNCS > (1 << FUNC_W)) begin : g_bad_num_funcs
    $error("rosb_top: NUM_FUNCS out of range");
  end

  // --------------------------------------------------------------------------
  // bus state
  // --------------------------------------------------------------------------
  typedef struct packed {
    rosb_phase_t phase;
    logic [2:0]  idx;
    logic        hit;
    logic [31:0] rdata;
  } rosb_bus_state_t;

  rosb_bus_state_t bus_reg;
  rosb_bus_state_t bus_next;

  rosb_sel_if sel ();

  logic       addr_valid;
  logic       addr_mapped;
  logic [2:0] addr_idx;
  logic [31:0] read_word;
  logic [31:0] fwd_word;

  assign addr_valid  = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);
  assign addr_mapped = (HADDR_I[31:8] == 24'h000000) && (HADDR_I[1:0] == 2'h0)
                       && (HADDR_I[7:0] <= OFS_LAST);
  assign addr_idx    = HADDR_I[4:2];

  // --------------------------------------------------------------------------
  // read view of the addressed register
  // --------------------------------------------------------------------------
  always_comb begin
    read_word = 32'h00000000;
    fwd_word  = 32'h00000000;
    // same masking as the stored codes
    fwd_word[ODD_LSB +: FUNC_W]  = HWDATA_I[ODD_LSB +: FUNC_W];
    fwd_word[EVEN_LSB +: FUNC_W] = HWDATA_I[EVEN_LSB +: FUNC_W];
    if (addr_mapped) begin
      // upper half and bits 15:14, 7:6 stay zero
      read_word[ODD_LSB +: FUNC_W]  = sel.odd_func[addr_idx];
      read_word[EVEN_LSB +: FUNC_W] = sel.even_func[addr_idx];
    end
  end

  // --------------------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // --------------------------------------------------------------------------
  always_comb begin
    bus_next       = bus_reg;
    bus_next.phase = ST_IDLE;
    if (addr_valid) begin
      bus_next.phase = HWRITE_I ? ST_WRITE : ST_READ;
      bus_next.idx   = addr_idx;
      bus_next.hit   = addr_mapped;
      bus_next.rdata = HWRITE_I ? 32'h00000000 : read_word;
      // a write still in its data phase lands only at this edge, so a read
      // of the same register right behind it takes the new codes
      if (!HWRITE_I && addr_mapped && sel.wr_en && sel.wr_idx == addr_idx) begin
        bus_next.rdata = fwd_word;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bus_reg <= '{phase: ST_IDLE, idx: 3'h0, hit: 1'b0, rdata: 32'h00000000};
    end else begin
      bus_reg <= bus_next;
    end
  end

  always_comb begin
    case (bus_reg.phase)
      ST_WRITE: sel.wr_en = bus_reg.hit;
      ST_READ:  sel.wr_en = 1'b0;
      ST_IDLE:  sel.wr_en = 1'b0;
      default:  sel.wr_en = 1'b0;
    endcase
  end

  assign sel.wr_idx  = bus_reg.idx;
  assign sel.wr_data = HWDATA_I[REG_W-1:0];
  assign HRDATA_O    = bus_reg.rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // --------------------------------------------------------------------------
  // selector registers and pin multiplexers
  // --------------------------------------------------------------------------
  // one register per pin pair; the write port index picks the one that takes a write
  rosb_sel_reg #(
    .IDX (3'h0)
  ) u_sel_46_47 (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESET_N_I),
    .wr_en_i     (sel.wr_en),
    .wr_idx_i    (sel.wr_idx),
    .wr_data_i   (sel.wr_data),
    .odd_func_o  (sel.odd_func[0]),
    .even_func_o (sel.even_func[0])
  );

  rosb_sel_reg #(
    .IDX (3'h1)
  ) u_sel_48_49 (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESET_N_I),
    .wr_en_i     (sel.wr_en),
    .wr_idx_i    (sel.wr_idx),
    .wr_data_i   (sel.wr_data),
    .odd_func_o  (sel.odd_func[1]),
    .even_func_o (sel.even_func[1])
  );

  rosb_sel_reg #(
    .IDX (3'h2)
  ) u_sel_50_51 (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESET_N_I),
    .wr_en_i     (sel.wr_en),
    .wr_idx_i    (sel.wr_idx),
    .wr_data_i   (sel.wr_data),
    .odd_func_o  (sel.odd_func[2]),
    .even_func_o (sel.even_func[2])
  );

  rosb_sel_reg #(
    .IDX (3'h3)
  ) u_sel_52_53 (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESET_N_I),
    .wr_en_i     (sel.wr_en),
    .wr_idx_i    (sel.wr_idx),
    .wr_data_i   (sel.wr_data),
    .odd_func_o  (sel.odd_func[3]),
    .even_func_o (sel.even_func[3])
  );

  rosb_sel_reg #(
    .IDX (3'h4)
  ) u_sel_54_55 (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESET_N_I),
    .wr_en_i     (sel.wr_en),
    .wr_idx_i    (sel.wr_idx),
    .wr_data_i   (sel.wr_data),
    .odd_func_o  (sel.odd_func[4]),
    .even_func_o (sel.even_func[4])
  );

  rosb_sel_reg #(
    .IDX (3'h5)
  ) u_sel_56_57 (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESET_N_I),
    .wr_en_i     (sel.wr_en),
    .wr_idx_i    (sel.wr_idx),
    .wr_data_i   (sel.wr_data),
    .odd_func_o  (sel.odd_func[5]),
    .even_func_o (sel.even_func[5])
  );

  rosb_sel_reg #(
    .IDX (3'h6)
  ) u_sel_58_59 (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESET_N_I),
    .wr_en_i     (sel.wr_en),
    .wr_idx_i    (sel.wr_idx),
    .wr_data_i   (sel.wr_data),
    .odd_func_o  (sel.odd_func[6]),
    .even_func_o (sel.even_func[6])
  );

  // --------------------------------------------------------------------------
  // pin multiplexers, one per remappable pin
  // --------------------------------------------------------------------------
  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_46 (
    .func_i       (sel.even_func[0]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[0])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_47 (
    .func_i       (sel.odd_func[0]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[1])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_48 (
    .func_i       (sel.even_func[1]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[2])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_49 (
    .func_i       (sel.odd_func[1]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[3])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_50 (
    .func_i       (sel.even_func[2]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[4])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_51 (
    .func_i       (sel.odd_func[2]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[5])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_52 (
    .func_i       (sel.even_func[3]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[6])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_53 (
    .func_i       (sel.odd_func[3]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[7])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_54 (
    .func_i       (sel.even_func[4]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[8])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_55 (
    .func_i       (sel.odd_func[4]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[9])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_56 (
    .func_i       (sel.even_func[5]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[10])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_57 (
    .func_i       (sel.odd_func[5]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[11])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_58 (
    .func_i       (sel.even_func[6]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[12])
  );

  rosb_pin_mux #(.NUM_FUNCS (NUM_FUNCS)) u_mux_59 (
    .func_i       (sel.odd_func[6]),
    .periph_out_i (PERIPH_OUT_I),
    .pin_o        (REMAP_PIN_O[13])
  );

  // --------------------------------------------------------------------------
  // stored codes, six bits per pin, pin 46 lowest
  // --------------------------------------------------------------------------
  assign PIN_OUT_FUNC_O[FUNC_W*0 +: FUNC_W]  = sel.even_func[0];
  assign PIN_OUT_FUNC_O[FUNC_W*1 +: FUNC_W]  = sel.odd_func[0];
  assign PIN_OUT_FUNC_O[FUNC_W*2 +: FUNC_W]  = sel.even_func[1];
  assign PIN_OUT_FUNC_O[FUNC_W*3 +: FUNC_W]  = sel.odd_func[1];
  assign PIN_OUT_FUNC_O[FUNC_W*4 +: FUNC_W]  = sel.even_func[2];
  assign PIN_OUT_FUNC_O[FUNC_W*5 +: FUNC_W]  = sel.odd_func[2];
  assign PIN_OUT_FUNC_O[FUNC_W*6 +: FUNC_W]  = sel.even_func[3];
  assign PIN_OUT_FUNC_O[FUNC_W*7 +: FUNC_W]  = sel.odd_func[3];
  assign PIN_OUT_FUNC_O[FUNC_W*8 +: FUNC_W]  = sel.even_func[4];
  assign PIN_OUT_FUNC_O[FUNC_W*9 +: FUNC_W]  = sel.odd_func[4];
  assign PIN_OUT_FUNC_O[FUNC_W*10 +: FUNC_W] = sel.even_func[5];
  assign PIN_OUT_FUNC_O[FUNC_W*11 +: FUNC_W] = sel.odd_func[5];
  assign PIN_OUT_FUNC_O[FUNC_W*12 +: FUNC_W] = sel.even_func[6];
  assign PIN_OUT_FUNC_O[FUNC_W*13 +: FUNC_W] = sel.odd_func[6];

endmodule

//--- test/rosb_monitor.sv
// checker: port assertions of the remappable output select bank
`timescale 1ns/1ps
module rosb_monitor
  import rosb_pkg::*;
#(
  parameter int NUM_FUNCS = 64
) (
  input wire logic                        CORE_CLK_I,
  input wire logic                        RESET_N_I,
  input wire logic                        HSEL_I,
  input wire logic [31:0]                 HADDR_I,
  input wire logic [1:0]                  HTRANS_I,
  input wire logic                        HWRITE_I,
  input wire logic [2:0]                  HSIZE_I,
  input wire logic [31:0]                 HWDATA_I,
  input wire logic                        HREADY_I,
  input wire logic [31:0]                 HRDATA_O,
  input wire logic                        HREADYOUT_O,
  input wire logic                        HRESP_O,
  input wire logic [NUM_FUNCS-1:0]        PERIPH_OUT_I,
  input wire logic [NUM_PINS-1:0]         REMAP_PIN_O,
  input wire logic [NUM_PINS*FUNC_W-1:0]  PIN_OUT_FUNC_O
);
  // --------------------------------------------------------------------------
  // first register, pins 46 and 47; the reset check and the zero-bit read data checks cover all registers
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_take0;
    HSEL_I && HREADY_I && HTRANS_I[1] && HADDR_I == 32'h0;
  endsequence
  sequence s_wr0;
    s_take0 and HWRITE_I ##1 HREADY_I;
  endsequence
  AST_ODD: assert property (s_wr0 |=> PIN_OUT_FUNC_O[11:6] == $past(HWDATA_I[13:8]))
    else $error("odd pin code not stored");
  AST_EVEN: assert property (s_wr0 |=> PIN_OUT_FUNC_O[5:0] == $past(HWDATA_I[5:0]))
    else $error("even pin code not stored");
  AST_TOP: assert property (HRDATA_O[15:14] == 2'h0)
    else $error("bits 15:14 read nonzero");
  AST_MID: assert property (HRDATA_O[7:6] == 2'h0)
    else $error("bits 7:6 read nonzero");
  AST_RST: assert property (!$past(RESET_N_I) |-> PIN_OUT_FUNC_O == '0)
    else $error("codes not cleared by reset");
  AST_READ: assert property (s_take0 and !HWRITE_I |=> HRDATA_O[15:0] ==
    {2'h0, PIN_OUT_FUNC_O[11:6], 2'h0, PIN_OUT_FUNC_O[5:0]})
    else $error("read data differs from stored codes");
  AST_HI16: assert property (HRDATA_O[31:16] == 16'h0)
    else $error("upper half of read data nonzero");
  AST_PIN: assert property (REMAP_PIN_O[0] == (PIN_OUT_FUNC_O[5:0] != 6'h0 &&
    PIN_OUT_FUNC_O[5:0] < NUM_FUNCS && PERIPH_OUT_I[PIN_OUT_FUNC_O[5:0]]))
    else $error("pin 46 not routed by its code");
endmodule
bind rosb_top rosb_monitor #(.NUM_FUNCS(NUM_FUNCS)) u_mon (.CORE_CLK_I, .RESET_N_I, .HSEL_I,
  .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I, .HWDATA_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O,
  .HRESP_O, .PERIPH_OUT_I, .REMAP_PIN_O, .PIN_OUT_FUNC_O);

//--- test/remappable_output_select_bank_test.sv
// testbench: register access, pin routing and reset of the selector bank
`timescale 1ns/1ps
module remappable_output_select_bank_test;
  import rosb_pkg::*;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [63:0] periph = 64'h0;
  logic [83:0] ef;
  wire logic        hready, hresp;
  wire logic [31:0] hrdata;
  wire logic [13:0] pins;
  wire logic [83:0] funcs;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  rosb_top #(.NUM_FUNCS(64)) u_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(HSIZE_WORD),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .PERIPH_OUT_I(periph), .REMAP_PIN_O(pins), .PIN_OUT_FUNC_O(funcs));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results;
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [83:0] e, input logic [83:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one single word transfer, zero or more wait states
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic t_reset_vals;
    periph <= '1;
    for (int i = 0; i < 7; i++) begin
      xfer(0, i * 4, 32'h0);
      chk("reset read", 84'h0, rd);
    end
    chk("reset pins", 84'h0, pins);
  endtask
  task automatic t_fields;
    ef = '0;
    for (int i = 0; i < 7; i++) begin
      xfer(1, i * 4, 32'hffff_ffff);
      xfer(0, i * 4, 32'h0);
      chk("masked read", 84'h3f3f, rd);
      xfer(1, i * 4, {16'hffff, 2'h3, 6'(2 * i + 2), 2'h3, 6'(2 * i + 1)});
      xfer(0, i * 4, 32'h0);
      chk("code read", {2'h0, 6'(2 * i + 2), 2'h0, 6'(2 * i + 1)}, rd);
      ef[12 * i +: 12] = {6'(2 * i + 2), 6'(2 * i + 1)};
    end
    chk("stored codes", ef, funcs);
  endtask
  task automatic t_route;
    logic [63:0] p;
    logic [13:0] ep;
    for (int j = 0; j < 3; j++) begin
      p = (j == 0) ? 64'haaaa_aaaa_aaaa_aaaa : (j == 1) ? 64'h5555_5555_5555_5555 : 64'h0;
      periph <= p;
      @(posedge clk);
      for (int k = 0; k < 14; k++) ep[k] = p[k + 1];
      chk("pin route", ep, pins);
    end
    periph <= '1;
    xfer(1, 32'h18, 32'h3f00);
    @(posedge clk);
    chk("code 0 and 63", 2'h2, pins[13:12]);
    ef[83:72] = 12'hfc0;
    xfer(1, 32'h1c, 32'h0101);
    xfer(0, 32'h1c, 32'h0);
    chk("unmapped read", 84'h0, rd);
    chk("unmapped resp", 84'h0, hresp);
    chk("codes kept", ef, funcs);
  endtask
  // write then read of one register back to back, read in the write's data phase
  task automatic t_wr_rd;
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    haddr <= 32'h4;
    do @(posedge clk); while (hready !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= 32'h0000_2a15;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge clk); while (hready !== 1'b1);
    chk("read after write", 84'h2a15, hrdata);
  endtask
  initial begin
    do_reset();
    t_reset_vals();
    t_fields();
    t_route();
    t_wr_rd();
    do_reset();
    @(posedge clk);
    chk("second reset", 84'h0, funcs);
    results();
  end
endmodule
